// file: rtl/phy_led_aux_map.vh
// register offsets, fields, reset values and timing counts for phy_led_aux
`ifndef PHY_LED_AUX_MAP_VH
`define PHY_LED_AUX_MAP_VH
// Contract
// [R1] loopback bit 5 returns transmit data to receive, nothing to media.
// [R2] status register 0x11 bit 7 shows loopback active.
// [R3] bit 4 reverses transmit and receive data bit order.
// [R4] auxiliary bits 3:1 written zero, read zero, no effect.
// [R5] bit 0 masks jabber conditions while in 10BASE-T mode.
// [R6] activity indicator lights on transmit, receive or idle error.
// [R7] mode field: 00 normal, 01 off, 10 blink, 11 on.
// [R8] blink mode toggles indicator with period near 750 ms.
// [R9] only mode 00 follows device status; others ignore it.
// [R10] 10 Mb/s link indicator lights on 10BASE-T link.
// [R11] 100 Mb/s link indicator lights on 100BASE-TX link.
// [R12] gigabit link indicator lights on 1000BASE-T link.
// [R13] duplex indicator lights on full duplex link.
// [R14] compact mode bit 5 repurposes 10 Mb/s link indicator.
// [R15] compact mode: 0x1A.0 = 1 link only, 0 link plus activity; the code takes this choice from the linkOnlySelect input.
// [R16] link steady on; link and activity blinks during traffic.
// [R17] indicator bits 4:0 plain read-write storage, reset zero.

// ****************************************************************
// register offsets
// ****************************************************************
`define STATUS_OFFSET            5'h11
`define AUXILIARY_CONTROL_OFFSET 5'h12
`define INDICATOR_CONTROL_OFFSET 5'h13
`define MGMT_PHY_ADDR            5'h01

// ****************************************************************
// fields and reset values
// ****************************************************************
`define AUX_LOOPBACK_BIT    5
`define AUX_REVERSE_BIT     4
`define AUX_JABBER_DIS_BIT  0
`define AUX_RESET           16'h0000
`define STATUS_LOOPBACK_BIT 7
`define IND_RESET           16'h0000
`define IND_ACTIVITY_LSB    14
`define IND_DUPLEX_LSB      6
`define IND_COMPACT_BIT     5
`define MODE_NORMAL         2'h0
`define MODE_OFF            2'h1
`define MODE_BLINK          2'h2
`define MODE_ON             2'h3

// ****************************************************************
// management frame and timing
// ****************************************************************
`define MDIO_PREAMBLE_BITS  6'd32
`define MDIO_OP_READ        2'h2
`define MDIO_OP_WRITE       2'h1
`define MDIO_HEAD_LAST      6'd12
`define MDIO_DATA_LAST      6'd15
`define REF_CLK_KHZ         20000
`define BLINK_PERIOD_MS     750
`define BLINK_HALF_CYCLES   ((`BLINK_PERIOD_MS * `REF_CLK_KHZ) / 2)
`endif

// file: rtl/blink_timer.v
// free running blink level generator for the indicators
`timescale 1ns/1ns
`include "phy_led_aux_map.vh"
module blink_timer #(
  parameter integer HALF_CYCLES = `BLINK_HALF_CYCLES
) (
  // clock and reset
  input  wire        clk,
  input  wire        rstSync_n,
  // blink level
  output reg         blinkLevel
);
  localparam integer LAST = HALF_CYCLES - 1;
  reg [22:0] count_q;

  // toggle every half period, full period is the blink period
  always @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      count_q    <= 23'h000000;
      blinkLevel <= 1'b0;
    end else if (count_q == LAST[22:0]) begin
      count_q    <= 23'h000000;
      blinkLevel <= ~blinkLevel; // [R8]
    end else begin
      count_q    <= count_q + 23'h000001;
    end
  end
endmodule // blink_timer

// file: rtl/indicator_mode.v
// decodes one two-bit indicator mode field into a lamp level
`timescale 1ns/1ns
`include "phy_led_aux_map.vh"
module indicator_mode (
  // mode and inputs
  input  wire [1:0] mode,
  input  wire       status,
  input  wire       blinkLevel,
  // lamp level
  output reg        lampOn
);
  // only normal mode looks at status
  always @* begin
    case (mode)
      `MODE_NORMAL: lampOn = status;      // [R7] [R9]
      `MODE_OFF:    lampOn = 1'b0;        // [R7]
      `MODE_BLINK:  lampOn = blinkLevel;  // [R7] [R8]
      default:      lampOn = 1'b1;        // [R7]
    endcase
  end
endmodule // indicator_mode

// file: rtl/phy_led_aux_control.v
// auxiliary control and indicator registers with management slave
`timescale 1ns/1ns
`include "phy_led_aux_map.vh"
module phy_led_aux_control #(
  parameter integer BLINK_HALF_CYCLES = `BLINK_HALF_CYCLES
) (
  // clock and reset
  input  wire       ref_clk,
  input  wire       rst_n,
  // management pins
  input  wire       mdc,
  input  wire       mdioIn,
  output reg        mdioOut,
  output reg        mdioOe,
  // mac transmit side
  input  wire [7:0] macTxd,
  input  wire       macTxEn,
  input  wire       macTxEr,
  // mac receive side
  output reg  [7:0] macRxd,
  output reg        macRxDv,
  output reg        macRxEr,
  // towards the media coding path
  output reg  [7:0] coreTxd,
  output reg        coreTxEn,
  output reg        coreTxEr,
  // from the media coding path
  input  wire [7:0] coreRxd,
  input  wire       coreRxDv,
  input  wire       coreRxEr,
  // link and traffic status
  input  wire       link10,
  input  wire       link100,
  input  wire       link1000,
  input  wire       fullDuplex,
  input  wire       txActive,
  input  wire       rxActive,
  input  wire       idleError,
  input  wire       jabberDetect,
  input  wire       linkOnlySelect,
  // jabber towards the 10BASE-T transmitter
  output reg        jabberActive,
  // indicator lamps
  output reg        activityLed,
  output reg        link10Led,
  output reg        link100Led,
  output reg        link1000Led,
  output reg        duplexLed
);

  // ****************************************************************
  // states of the management slave
  // ****************************************************************
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_HEAD = 4'b0010;
  localparam [3:0] ST_TURN = 4'b0100;
  localparam [3:0] ST_DATA = 4'b1000;

  // ****************************************************************
  // declarations
  // ****************************************************************
  reg        rstMeta_n;
  reg        rstSync_n;
  reg        mdcMeta_q;
  reg        mdcSync_q;
  reg        mdcLast_q;
  reg        mdioMeta_q;
  reg        mdioSync_q;
  reg [3:0]  state_q;
  reg [5:0]  bitCnt_q;
  reg [15:0] shift_q;
  reg        isRead_q;
  reg        hit_q;
  reg [4:0]  regAddr_q;
  reg [15:0] aux_q;
  reg [15:0] ind_q;
  reg        writeEn;
  reg [15:0] writeData;
  reg [15:0] readData;
  reg        mapped;
  wire       mdcRise;
  wire [12:0] header;
  wire       loopOn;
  wire       reverseOn;
  wire [7:0] txOrdered;
  wire [7:0] rxSource;
  wire       anyLink;
  wire       activity;
  wire       blinkLevel;
  wire       link10Status;
  wire [4:0] statusVec;
  wire [4:0] lampNext;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // bit order swap, bit 7 goes to bit 0
  function [7:0] bitReverse;
    input [7:0] d;
    integer k;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        bitReverse[k] = d[7 - k];
      end
    end
  endfunction

  // ****************************************************************
  // reset release and pin synchronisers
  // ****************************************************************
  // reset asserts at once and releases through two flops
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_n <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_n <= 1'b1;
      rstSync_n <= rstMeta_n;
    end
  end

  // management clock and data pass two flops each
  always @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      mdcMeta_q  <= 1'b0;
      mdcSync_q  <= 1'b0;
      mdcLast_q  <= 1'b0;
      mdioMeta_q <= 1'b1;
      mdioSync_q <= 1'b1;
    end else begin
      mdcMeta_q  <= mdc;
      mdcSync_q  <= mdcMeta_q;
      mdcLast_q  <= mdcSync_q;
      mdioMeta_q <= mdioIn;
      mdioSync_q <= mdioMeta_q;
    end
  end

  assign mdcRise = mdcSync_q & ~mdcLast_q;
  // start bit, opcode, phy address, register address
  assign header  = {shift_q[11:0], mdioSync_q};

  // ****************************************************************
  // register read multiplexer
  // ****************************************************************
  // unmapped addresses leave the data line released
  always @* begin
    readData = 16'h0000;
    mapped   = 1'b1;
    if (header[4:0] == `STATUS_OFFSET) begin
      readData[`STATUS_LOOPBACK_BIT] = loopOn; // [R2]
    end else if (header[4:0] == `AUXILIARY_CONTROL_OFFSET) begin
      readData = aux_q; // [R4]
    end else if (header[4:0] == `INDICATOR_CONTROL_OFFSET) begin
      readData = ind_q;
    end else begin
      mapped   = 1'b0;
    end
  end

  // ****************************************************************
  // management frame slave
  // ****************************************************************
  // preamble, header, turnaround, sixteen data bits msb first
  always @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      state_q   <= ST_IDLE;
      bitCnt_q  <= 6'd0;
      shift_q   <= 16'h0000;
      isRead_q  <= 1'b0;
      hit_q     <= 1'b0;
      regAddr_q <= 5'h00;
      mdioOut   <= 1'b0;
      mdioOe    <= 1'b0;
      writeEn   <= 1'b0;
      writeData <= 16'h0000;
    end else begin
      writeEn <= 1'b0;
      if (mdcRise) begin
        case (state_q)
          ST_IDLE: begin
            if (mdioSync_q) begin
              if (bitCnt_q != `MDIO_PREAMBLE_BITS) begin
                bitCnt_q <= bitCnt_q + 6'd1;
              end
            end else if (bitCnt_q == `MDIO_PREAMBLE_BITS) begin
              bitCnt_q <= 6'd0;
              state_q  <= ST_HEAD;
            end else begin
              bitCnt_q <= 6'd0;
            end
          end
          ST_HEAD: begin
            shift_q  <= {shift_q[14:0], mdioSync_q};
            bitCnt_q <= bitCnt_q + 6'd1;
            if (bitCnt_q == `MDIO_HEAD_LAST) begin
              bitCnt_q  <= 6'd0;
              state_q   <= ST_TURN;
              regAddr_q <= header[4:0];
              isRead_q  <= header[11:10] == `MDIO_OP_READ;
              hit_q     <= header[12] &
                           (header[9:5] == `MGMT_PHY_ADDR) &
                           ((header[11:10] == `MDIO_OP_READ) |
                            (header[11:10] == `MDIO_OP_WRITE)) &
                           mapped;
              shift_q   <= readData;
            end
          end
          ST_TURN: begin
            bitCnt_q <= bitCnt_q + 6'd1;
            if (bitCnt_q == 6'd0) begin
              // second turnaround bit driven low on reads
              mdioOe  <= hit_q & isRead_q;
              mdioOut <= 1'b0;
            end else begin
              bitCnt_q <= 6'd0;
              state_q  <= ST_DATA;
              mdioOut  <= shift_q[15];
              shift_q  <= {shift_q[14:0], 1'b0};
            end
          end
          ST_DATA: begin
            bitCnt_q <= bitCnt_q + 6'd1;
            if (isRead_q) begin
              mdioOut <= shift_q[15];
              shift_q <= {shift_q[14:0], 1'b0};
            end else begin
              shift_q <= {shift_q[14:0], mdioSync_q};
            end
            if (bitCnt_q == `MDIO_DATA_LAST) begin
              bitCnt_q  <= 6'd0;
              state_q   <= ST_IDLE;
              mdioOe    <= 1'b0;
              mdioOut   <= 1'b0;
              writeEn   <= hit_q & ~isRead_q;
              writeData <= {shift_q[14:0], mdioSync_q};
            end
          end
          default: begin
            state_q  <= ST_IDLE;
            bitCnt_q <= 6'd0;
            mdioOe   <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  // auxiliary keeps only loopback, reversal and jabber disable
  always @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      aux_q <= `AUX_RESET;
      ind_q <= `IND_RESET;
    end else if (writeEn) begin
      if (regAddr_q == `AUXILIARY_CONTROL_OFFSET) begin
        aux_q <= `AUX_RESET; // [R4]
        aux_q[`AUX_LOOPBACK_BIT]   <= writeData[`AUX_LOOPBACK_BIT];
        aux_q[`AUX_REVERSE_BIT]    <= writeData[`AUX_REVERSE_BIT];
        aux_q[`AUX_JABBER_DIS_BIT] <= writeData[`AUX_JABBER_DIS_BIT];
      end else if (regAddr_q == `INDICATOR_CONTROL_OFFSET) begin
        ind_q <= writeData; // [R17]
      end
    end
  end

  // ****************************************************************
  // gmii data path
  // ****************************************************************
  assign loopOn    = aux_q[`AUX_LOOPBACK_BIT];
  assign reverseOn = aux_q[`AUX_REVERSE_BIT];
  assign txOrdered = reverseOn ? bitReverse(macTxd) : macTxd; // [R3]
  assign rxSource  = loopOn ? txOrdered : coreRxd; // [R1]

  // loopback turns transmit around and silences the media side
  always @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      macRxd   <= 8'h00;
      macRxDv  <= 1'b0;
      macRxEr  <= 1'b0;
      coreTxd  <= 8'h00;
      coreTxEn <= 1'b0;
      coreTxEr <= 1'b0;
    end else begin
      macRxd   <= reverseOn ? bitReverse(rxSource) : rxSource; // [R3]
      macRxDv  <= loopOn ? macTxEn : coreRxDv; // [R1]
      macRxEr  <= loopOn ? macTxEr : coreRxEr; // [R1]
      coreTxd  <= loopOn ? 8'h00 : txOrdered; // [R1]
      coreTxEn <= macTxEn & ~loopOn; // [R1]
      coreTxEr <= macTxEr & ~loopOn; // [R1]
    end
  end

  // ****************************************************************
  // jabber gate
  // ****************************************************************
  // disable only matters while the link runs 10BASE-T
  always @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      jabberActive <= 1'b0;
    end else begin
      jabberActive <= jabberDetect &
                      ~(aux_q[`AUX_JABBER_DIS_BIT] & link10); // [R5]
    end
  end

  // ****************************************************************
  // indicator status
  // ****************************************************************
  assign anyLink  = link10 | link100 | link1000;
  assign activity = txActive | rxActive | idleError; // [R6]

  // compact mode shows link, or link with blinking traffic
  assign link10Status = ~ind_q[`IND_COMPACT_BIT] ? link10 :
                        linkOnlySelect ? anyLink :
                        anyLink & (~activity | blinkLevel); // [R14] [R15] [R16]

  assign statusVec = {activity, link10Status, link100, link1000,
                      fullDuplex & anyLink}; // [R10] [R11] [R12] [R13]

  blink_timer #(
    .HALF_CYCLES (BLINK_HALF_CYCLES)
  ) u_blink (
    .clk        (ref_clk),
    .rstSync_n  (rstSync_n),
    .blinkLevel (blinkLevel)
  );

  // one mode decoder per lamp, fields from bit 6 upward
  genvar i;
  generate
    for (i = 0; i < 5; i = i + 1) begin : g_lamp
      indicator_mode u_mode (
        .mode       (ind_q[`IND_DUPLEX_LSB + 2 * i +: 2]),
        .status     (statusVec[i]),
        .blinkLevel (blinkLevel),
        .lampOn     (lampNext[i])
      );
    end
  endgenerate

  // ****************************************************************
  // lamp outputs
  // ****************************************************************
  // registered so the pins never glitch
  always @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      activityLed <= 1'b0;
      link10Led   <= 1'b0;
      link100Led  <= 1'b0;
      link1000Led <= 1'b0;
      duplexLed   <= 1'b0;
    end else begin
      activityLed <= lampNext[4]; // [R6] [R9]
      link10Led   <= lampNext[3]; // [R10]
      link100Led  <= lampNext[2]; // [R11]
      link1000Led <= lampNext[1]; // [R12]
      duplexLed   <= lampNext[0]; // [R13]
    end
  end

endmodule // phy_led_aux_control

// file: verif/mgmt_agent.sv
// management bus master model standing in for host software
`timescale 1ns/1ns
`include "phy_led_aux_map.vh"
module mgmt_agent (
  // clock
  input  wire ref_clk,
  // management pins
  output reg  mdc,
  output wire mdioLine,
  input  wire mdioOut,
  input  wire mdioOe
);
  reg drive;
  reg bitOut;
  // pull-up keeps the line high when nobody drives
  assign mdioLine = mdioOe ? mdioOut : (drive ? bitOut : 1'b1);
  // clock stands low outside frames
  initial begin
    mdc = 1'b0;
    drive = 1'b0;
    bitOut = 1'b1;
  end
  // one frame with fresh preamble, data msb first, idle bit at the end
  task frame(input [1:0] op, input [4:0] ra, input [15:0] wd,
             output [15:0] rd);
    reg [63:0] f;
    integer i;
    begin
      f = {32'hffffffff, 2'b01, op, `MGMT_PHY_ADDR, ra, 2'b10, wd};
      rd = 16'h0000;
      for (i = 63; i >= -1; i = i - 1) begin
        drive = (i >= 0) && (op == `MDIO_OP_WRITE || i > 17);
        bitOut = (i >= 0) ? f[i] : 1'b1;
        repeat (4) @(posedge ref_clk);
        #1 mdc = 1'b1;
        if (i >= 0 && i < 16) rd[i] = mdioLine;
        repeat (4) @(posedge ref_clk);
        #1 mdc = 1'b0;
      end
      drive = 1'b0;
    end
  endtask
endmodule // mgmt_agent

// file: verif/phy_led_aux_control_properties.sv
// concurrent checks on the ports of phy_led_aux_control
`timescale 1ns/1ns
module phy_led_aux_control_properties #(
  parameter integer BLINK_HALF_CYCLES = 4
) (
  // clock and reset
  input wire       ref_clk,
  input wire       rst_n,
  // management pins
  input wire       mdioOut,
  input wire       mdioOe,
  // datapath
  input wire [7:0] macTxd,
  input wire       macTxEn,
  input wire       macTxEr,
  input wire       macRxDv,
  input wire       macRxEr,
  input wire [7:0] coreTxd,
  input wire       coreTxEn,
  input wire       coreTxEr,
  input wire       coreRxDv,
  input wire       coreRxEr,
  // jabber
  input wire       link10,
  input wire       jabberDetect,
  input wire       jabberActive
);
  reg  [2:0] age_q;
  wire [7:0] txRev;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // cycles since reset release, saturating
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) age_q <= 3'h0;
    else if (age_q != 3'h7) age_q <= age_q + 3'h1;
  end
  // mirrored transmit byte
  assign txRev = {<<{macTxd}};
  sequence turnZero;
    mdioOe && !mdioOut;
  endsequence
  sequence loopSeen;
    macRxDv && !$past(coreRxDv);
  endsequence
  tx_source_a: assert property (coreTxEn |-> $past(macTxEn))
    else $error("media enable without mac enable");
  tx_error_a: assert property (coreTxEr |-> $past(macTxEr))
    else $error("media error without mac error");
  loop_excl_a: assert property (loopSeen |-> !coreTxEn && !coreTxEr)
    else $error("media driven during loopback");
  rx_source_a: assert property (macRxDv |-> $past(coreRxDv) ||
    $past(macTxEn)) else $error("receive valid without source");
  rx_error_a: assert property (macRxEr |-> $past(coreRxEr) ||
    $past(macTxEr)) else $error("receive error without source");
  tx_order_a: assert property (coreTxEn |->
    coreTxd == $past(macTxd) || coreTxd == $past(txRev))
    else $error("media byte not mac byte");
  jabber_src_a: assert property (jabberActive |-> $past(jabberDetect))
    else $error("jabber without detect");
  jabber_pass_a: assert property (age_q > 3'h3 && jabberDetect &&
    !link10 |=> jabberActive) else $error("jabber lost outside 10 mode");
  turn_zero_a: assert property ($rose(mdioOe) |-> turnZero)
    else $error("turnaround bit not zero");
endmodule // phy_led_aux_control_properties

bind phy_led_aux_control phy_led_aux_control_properties #(
  .BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)) chk_u (.ref_clk(ref_clk),
  .rst_n(rst_n), .mdioOut(mdioOut), .mdioOe(mdioOe), .macTxd(macTxd),
  .macTxEn(macTxEn), .macTxEr(macTxEr), .macRxDv(macRxDv),
  .macRxEr(macRxEr), .coreTxd(coreTxd), .coreTxEn(coreTxEn),
  .coreTxEr(coreTxEr), .coreRxDv(coreRxDv), .coreRxEr(coreRxEr),
  .link10(link10), .jabberDetect(jabberDetect),
  .jabberActive(jabberActive));

// file: verif/tb_top.sv
// self-checking bench for the auxiliary and indicator registers
`timescale 1ns/1ns
`include "phy_led_aux_map.vh"
module tb_top;
  localparam integer HALF = 4;
  reg        ref_clk, rst_n, macTxEn, macTxEr, coreRxDv, coreRxEr;
  reg  [7:0] macTxd, coreRxd;
  reg        link10, link100, link1000, fullDuplex, txActive, rxActive;
  reg        idleError, jabberDetect, linkOnlySelect;
  wire       mdc, mdioLine, mdioOut, mdioOe, macRxDv, macRxEr;
  wire       coreTxEn, coreTxEr, jabberActive;
  wire [7:0] macRxd, coreTxd;
  wire [4:0] leds;
  integer    mismatches, checks, cycles;
  reg [15:0] rd;
  reg  [4:0] ledsB;
  reg  [2:0] m;
  phy_led_aux_control #(.BLINK_HALF_CYCLES(HALF)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .mdc(mdc), .mdioIn(mdioLine),
    .mdioOut(mdioOut), .mdioOe(mdioOe), .macTxd(macTxd),
    .macTxEn(macTxEn), .macTxEr(macTxEr), .macRxd(macRxd),
    .macRxDv(macRxDv), .macRxEr(macRxEr), .coreTxd(coreTxd),
    .coreTxEn(coreTxEn), .coreTxEr(coreTxEr), .coreRxd(coreRxd),
    .coreRxDv(coreRxDv), .coreRxEr(coreRxEr), .link10(link10),
    .link100(link100), .link1000(link1000), .fullDuplex(fullDuplex),
    .txActive(txActive), .rxActive(rxActive), .idleError(idleError),
    .jabberDetect(jabberDetect), .linkOnlySelect(linkOnlySelect),
    .jabberActive(jabberActive), .activityLed(leds[4]),
    .link10Led(leds[3]), .link100Led(leds[2]), .link1000Led(leds[1]),
    .duplexLed(leds[0]));
  mgmt_agent mgmt_u (.ref_clk(ref_clk), .mdc(mdc), .mdioLine(mdioLine),
    .mdioOut(mdioOut), .mdioOe(mdioOe));
  // compare and count
  task check(input [95:0] what, input [15:0] seen, input [15:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("[ERR] %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge ref_clk);
      #1;
    end
  endtask
  task wr(input [4:0] ra, input [15:0] d);
    begin
      mgmt_u.frame(`MDIO_OP_WRITE, ra, d, rd);
    end
  endtask
  task rdchk(input [4:0] ra, input [15:0] exp);
    begin
      mgmt_u.frame(`MDIO_OP_READ, ra, 16'h0000, rd);
      check("register", rd, exp);
    end
  endtask
  // set status levels, let the lamps settle, compare
  task lamp(input [6:0] st, input [4:0] exp);
    begin
      {link10, link100, link1000, fullDuplex, txActive, rxActive,
       idleError} = st;
      tick(3);
      check("lamps", {11'h000, leds}, {11'h000, exp});
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // clock generator
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // cycle ceiling against a hang
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 30000) begin
      mismatches = mismatches + 1;
      summarize;
    end
  end
  // main sequence
  initial begin
    mismatches = 0;
    checks = 0;
    cycles = 0;
    rst_n = 1'b0;
    {macTxEn, macTxEr, coreRxDv, coreRxEr, jabberDetect} = 5'h00;
    {linkOnlySelect, macTxd, coreRxd} = 17'h00000;
    {link10, link100, link1000, fullDuplex, txActive, rxActive,
     idleError} = 7'h00;
    tick(2);
    check("reset lamps", {11'h000, leds}, 16'h0000);
    rst_n = 1'b1;
    tick(4);
    rdchk(`AUXILIARY_CONTROL_OFFSET, `AUX_RESET);
    rdchk(`INDICATOR_CONTROL_OFFSET, `IND_RESET);
    rdchk(5'h14, 16'hffff);
    wr(`INDICATOR_CONTROL_OFFSET, 16'h001f);
    rdchk(`INDICATOR_CONTROL_OFFSET, 16'h001f);
    wr(`AUXILIARY_CONTROL_OFFSET, 16'h003f);
    rdchk(`AUXILIARY_CONTROL_OFFSET, 16'h0031);
    rdchk(`STATUS_OFFSET, 16'h0080);
    // loopback with reversal returns the sent byte, media silent
    {macTxd, macTxEn, macTxEr, coreRxd} = {8'ha1, 2'h3, 8'h5c};
    tick(1);
    check("loop rxd", macRxd, 8'ha1);
    check("loop txd", coreTxd, 8'h00);
    check("loop ctl", {macRxDv, macRxEr, coreTxEn, coreTxEr}, 4'hc);
    {link10, jabberDetect} = 2'h3;
    tick(2);
    check("jab masked", jabberActive, 1'b0);
    link10 = 1'b0;
    tick(2);
    check("jab other", jabberActive, 1'b1);
    wr(`AUXILIARY_CONTROL_OFFSET, 16'h0010);
    {macTxd, coreRxd, coreRxDv, coreRxEr, link10} = {8'h01, 8'h03, 3'h7};
    tick(2);
    check("rev txd", coreTxd, 8'h80);
    check("rev rxd", macRxd, 8'hc0);
    check("jab on", {macRxDv, macRxEr, coreTxEn, coreTxEr, jabberActive},
          5'h1f);
    rdchk(`STATUS_OFFSET, 16'h0000);
    wr(`INDICATOR_CONTROL_OFFSET, 16'h0000);
    lamp(7'h40, 5'h08);
    lamp(7'h20, 5'h04);
    lamp(7'h10, 5'h02);
    lamp(7'h18, 5'h03);
    lamp(7'h0c, 5'h10);
    lamp(7'h02, 5'h10);
    lamp(7'h01, 5'h10);
    // every non-normal mode on all five fields
    for (m = 3'h1; m < 3'h4; m = m + 3'h1) begin
      wr(`INDICATOR_CONTROL_OFFSET, {{5{m[1:0]}}, 6'h00});
      if (m != 3'h2) lamp(m == 3'h1 ? 7'h7f : 7'h00, {5{m[1]}});
      else begin
        ledsB = leds;
        tick(HALF);
        check("blink half", {11'h000, leds}, {11'h000, ~ledsB});
        tick(HALF);
        check("blink full", {11'h000, leds}, {11'h000, ledsB});
      end
    end
    wr(`INDICATOR_CONTROL_OFFSET, 16'h0020);
    linkOnlySelect = 1'b1;
    lamp(7'h20, 5'h0c);
    lamp(7'h24, 5'h1c);
    linkOnlySelect = 1'b0;
    lamp(7'h20, 5'h0c);
    // traffic on a link: steady lamps fixed, compact lamp blinks
    {link10, link100, link1000, fullDuplex, txActive, rxActive,
     idleError} = 7'h24;
    tick(3);
    check("compact fix", {11'h000, leds & 5'h17}, 16'h0014);
    ledsB = leds;
    tick(HALF);
    check("compact act", {11'h000, leds}, {11'h000, ledsB ^ 5'h08});
    tick(HALF);
    check("compact back", {11'h000, leds}, {11'h000, ledsB});
    summarize;
  end
endmodule // tb_top
